// ===== logic/vsp_sync_proc.sv
// Contract
// [R1] Coast blocks sync to PLL; asynchronous input
// [R2] Coast from internal, vertical pin or external
// [R3] Board ties coast inactive with separate hsync
// [R4] Slicer level five-bit field; composite sync out
// [R5] Eight-bit separator counter, polarity independent
// [R6] Reject pulses shorter than N times 200ns
// [R7] Count up in pulse, down between; detect
// [R8] On detect reset, count out, then restart
// [R9] Separated vsync lags by threshold time
// [R10] Separator input from slicer or hsync pin
// [R11] Regenerator automatic, tolerant of extra/missing pulses
// [R12] Filter accepts edges within plus/minus x*25ns; code uses x*20ns (WIN_UNIT_CYC is two 10ns cycles)
// [R13] Sticky status bit on extraneous pulses
// [R14] Select filtered or raw sync for PLL
// [R15] Select regenerated or raw sync for processing
// [R16] Vsync filter keeps edges apart from hsync
// [R17] Software keeps vsync filter enabled
// [R18] Field, syncs, line count, sync-on-green outputs
// [R19] Field type from vsync position in line
//
// Local design decisions: the APB register port and the register addresses.
module vsp_sync_proc
	import vsp_pkg::*;
#(
	parameter int PHASE_W = 14,
	parameter int LINE_W = 12
)
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic hsync_in,
	input wire logic vsync_in,
	input wire logic green_sync_input,
	input wire logic coast_in,
	output logic [4:0] slice_level,
	output logic sync_on_green,
	output logic pll_sync,
	output logic pll_coast,
	output logic hsync_out,
	output logic vertical_sync_output,
	output logic field_odd
);
	logic [1:0] hs_sy_ff, vs_sy_ff, sl_sy_ff, co_sy_ff;
	logic [7:0] thresh_ff, window_ff, ctrl_ff;
	logic [2:0] coast_cfg_ff;
	logic [4:0] slice_ff;
	logic extra_ff, lock_ff, field_ff, vs_out_ff, hs_out_ff, sog_ff;
	logic [LINE_W-1:0] line_cnt_ff, line_acc_ff;
	logic [4:0] tick_cnt_ff;
	logic tick;
	logic [7:0] pol_cnt_ff, sep_cnt_ff;
	vsp_sep_t sep_st_ff;
	logic csync, csync_act, src_prev_ff, src_act, src_edge;
	logic [PHASE_W-1:0] phase_ff, period_ff, win_cyc;
	logic [3:0] miss_ff;
	logic in_win, late_edge, regen_edge, period_match;
	logic [5:0] regen_w_ff;
	logic filt_ff, regen_hs, proc_hs, proc_prev_ff, vs_src, vs_gate;
	logic coast, wr_en, rd_en, hit;
	logic [7:0] idx;

	// Pins cross into core_clk through two flops before use
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			hs_sy_ff <= 2'h0;
			vs_sy_ff <= 2'h0;
			sl_sy_ff <= 2'h0;
			co_sy_ff <= 2'h0;
		end
		else
		begin
			hs_sy_ff <= {hs_sy_ff[0], hsync_in};
			vs_sy_ff <= {vs_sy_ff[0], vsync_in};
			sl_sy_ff <= {sl_sy_ff[0], green_sync_input};
			co_sy_ff <= {co_sy_ff[0], coast_in}; // R1
		end
	end

	assign idx = paddr[9:2];
	assign wr_en = psel && penable && pwrite;
	assign rd_en = psel && !pwrite;
	assign pready = 1'b1;
	always_comb
	begin
		hit = 1'b1;
		case (idx)
			IDX_SEP_THRESH, IDX_COAST_CFG, IDX_STATUS, IDX_SLICE_LEVEL,
			IDX_HS_WINDOW, IDX_SYNC_CTRL, IDX_LINE_COUNT: hit = 1'b1;
			default: hit = 1'b0;
		endcase
	end
	assign pslverr = psel && penable && (!hit || paddr[1:0] != 2'h0);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			thresh_ff <= RST_SEP_THRESH;
			coast_cfg_ff <= RST_COAST_CFG;
			slice_ff <= RST_SLICE_LEVEL;
			window_ff <= RST_HS_WINDOW;
			ctrl_ff <= RST_SYNC_CTRL;
		end
		else if (wr_en && !pslverr)
		begin
			case (idx)
				IDX_SEP_THRESH: thresh_ff <= pwdata[7:0]; // R6
				IDX_COAST_CFG: coast_cfg_ff <= pwdata[2:0];
				IDX_SLICE_LEVEL: slice_ff <= pwdata[7:3]; // R4
				IDX_HS_WINDOW: window_ff <= pwdata[7:0]; // R12
				IDX_SYNC_CTRL: ctrl_ff <= {pwdata[7:4], 4'h0};
				default: ;
			endcase
		end
	end

	// Read data is registered in the setup cycle, ready at the access edge
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			prdata <= 32'h0;
		else if (rd_en && !penable && paddr[1:0] != 2'h0)
			prdata <= 32'h0;
		else if (rd_en && !penable)
		begin
			case (idx)
				IDX_SEP_THRESH: prdata <= {24'h0, thresh_ff};
				IDX_COAST_CFG: prdata <= {29'h0, coast_cfg_ff};
				IDX_STATUS: prdata <= {28'h0, lock_ff, vs_out_ff, field_ff,
					extra_ff};
				IDX_SLICE_LEVEL: prdata <= {24'h0, slice_ff, 3'h0};
				IDX_HS_WINDOW: prdata <= {24'h0, window_ff};
				IDX_SYNC_CTRL: prdata <= {24'h0, ctrl_ff};
				IDX_LINE_COUNT: prdata <= {{(32-LINE_W){1'b0}}, line_cnt_ff};
				default: prdata <= 32'h0;
			endcase
		end
	end

	// The analog slicer compares against this level; its result is sliced
	assign slice_level = slice_ff; // R4
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			sog_ff <= 1'b0;
		else
			sog_ff <= sl_sy_ff[1]; // R18
	end
	assign sync_on_green = sog_ff;

	// Separator tick: one count per nominal 200ns unit
	assign tick = (tick_cnt_ff == 5'(SEP_TICK_CYC - 1));
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			tick_cnt_ff <= 5'h0;
		else
			tick_cnt_ff <= tick ? 5'h0 : tick_cnt_ff + 5'h1;
	end

	assign csync = ctrl_ff[CTRL_CSRC_BIT] ? hs_sy_ff[1] : sl_sy_ff[1]; // R10

	// Sync is short duty: if the line is mostly high it is active low
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			pol_cnt_ff <= 8'h80;
		else if (tick)
		begin
			if (csync && pol_cnt_ff != 8'hff)
				pol_cnt_ff <= pol_cnt_ff + 8'h1;
			else if (!csync && pol_cnt_ff != 8'h00)
				pol_cnt_ff <= pol_cnt_ff - 8'h1;
		end
	end
	assign csync_act = pol_cnt_ff[7] ? !csync : csync; // R5

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			sep_st_ff <= VSP_SEEK;
			sep_cnt_ff <= 8'h0;
		end
		else
		begin
			case (sep_st_ff)
				VSP_SEEK:
				begin
					if (sep_cnt_ff > thresh_ff) // R6
					begin
						sep_st_ff <= VSP_HOLD; // R7
						sep_cnt_ff <= 8'h0; // R8
					end
					else if (tick && csync_act && sep_cnt_ff != 8'hff)
						sep_cnt_ff <= sep_cnt_ff + 8'h1; // R7
					else if (tick && !csync_act && sep_cnt_ff != 8'h0)
						sep_cnt_ff <= sep_cnt_ff - 8'h1; // R7
				end
				VSP_HOLD:
				begin
					if (csync_act)
						sep_cnt_ff <= 8'h0; // R8
					else if (sep_cnt_ff >= thresh_ff)
					begin
						sep_st_ff <= VSP_SEEK; // R8
						sep_cnt_ff <= 8'h0;
					end
					else if (tick)
						sep_cnt_ff <= sep_cnt_ff + 8'h1; // R8
				end
				default:
				begin
					sep_st_ff <= VSP_SEEK;
					sep_cnt_ff <= 8'h0;
				end
			endcase
		end
	end
	// Separated vsync is the HOLD state, so it lags by the threshold
	assign vs_src = coast_cfg_ff[COAST_VSRC_BIT] ? vs_sy_ff[1] :
		(sep_st_ff == VSP_HOLD); // R9

	// Horizontal flywheel on leading edges of the normalised sync
	assign src_act = csync_act;
	assign src_edge = src_act && !src_prev_ff;
	assign win_cyc = PHASE_W'(window_ff) * PHASE_W'(WIN_UNIT_CYC);
	assign in_win = (phase_ff <= win_cyc) ||
		(phase_ff + win_cyc >= period_ff); // R12
	// Once locked, early edges are ignored so serrations cannot pull the flywheel
	assign late_edge = phase_ff >= period_ff - (period_ff >> 3);
	assign regen_edge = (lock_ff && phase_ff == period_ff) ||
		(src_edge && (late_edge || !lock_ff)); // R11
	// Lock once two intervals agree; a lone edge after reset locks only if the phase is within the window of the all-ones reset period
	assign period_match =
		({1'b0, phase_ff} + {1'b0, win_cyc} >= {1'b0, period_ff}) &&
		({1'b0, phase_ff} <= {1'b0, period_ff} + {1'b0, win_cyc});

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			src_prev_ff <= 1'b0;
		else
			src_prev_ff <= src_act;
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			phase_ff <= '0;
			period_ff <= '1;
			miss_ff <= 4'h0;
			lock_ff <= 1'b0;
		end
		else
		begin
			if (src_edge && (late_edge || !lock_ff))
			begin
				period_ff <= phase_ff; // R11
				phase_ff <= '0;
				miss_ff <= 4'h0;
				lock_ff <= lock_ff || period_match;
			end
			else if (lock_ff && phase_ff == period_ff)
			begin
				phase_ff <= '0;
				// Missing pulses coast through; many in a row unlock
				if (miss_ff == 4'(LOCK_MISS_LIMIT - 1))
					lock_ff <= 1'b0;
				else
					miss_ff <= miss_ff + 4'h1; // R11
			end
			else if (phase_ff != '1)
				// Unlocked, the phase measures the gap to the next edge
				phase_ff <= phase_ff + 1'b1;
		end
	end

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			regen_w_ff <= 6'h0;
		else if (regen_edge)
			regen_w_ff <= 6'(REGEN_WIDTH_CYC); // R11
		else if (regen_w_ff != 6'h0)
			regen_w_ff <= regen_w_ff - 6'h1;
	end
	assign regen_hs = (regen_w_ff != 6'h0);

	// Filtered sync rises only for leading edges inside the window; it falls with the input
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			filt_ff <= 1'b0;
		else if (src_edge && in_win)
			filt_ff <= 1'b1; // R12
		else if (!src_act)
			filt_ff <= 1'b0;
	end

	// Sticky; a new extra edge in the clearing cycle keeps it set
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
			extra_ff <= 1'b0;
		else if (src_edge && lock_ff && !in_win)
			extra_ff <= 1'b1; // R13
		else if (wr_en && !pslverr && idx == IDX_STATUS &&
			pwdata[STAT_EXTRA_BIT])
			extra_ff <= 1'b0;
	end

	always_comb
	begin
		if (coast_cfg_ff[COAST_INT_BIT])
			coast = (sep_st_ff == VSP_HOLD); // R2
		else if (coast_cfg_ff[COAST_PIN_BIT])
			coast = vs_sy_ff[1]; // R2
		else
			coast = co_sy_ff[1]; // R2
	end
	assign pll_coast = coast;
	// Blocked sync leaves the PLL free-running at its present rate
	assign pll_sync = coast ? 1'b0 :
		(ctrl_ff[CTRL_FILT_BIT] ? filt_ff : src_act); // R1 R14

	assign proc_hs = ctrl_ff[CTRL_REGEN_BIT] ? regen_hs : src_act; // R15
	// Hold vsync back while an hsync leading edge is near
	// Unlocked there is no line to measure; wait for the regenerated hsync pulse (regen_w_ff) to end
	assign vs_gate = lock_ff ? ((phase_ff >= PHASE_W'(VS_GUARD_CYC)) &&
		(phase_ff + PHASE_W'(VS_GUARD_CYC) < period_ff)) :
		(regen_w_ff == 6'h0);

	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			vs_out_ff <= 1'b0;
			field_ff <= 1'b0;
		end
		else if (!vs_src)
			vs_out_ff <= 1'b0;
		else if (!vs_out_ff && (vs_gate || !ctrl_ff[CTRL_VSF_BIT])) // R16
		begin
			vs_out_ff <= 1'b1;
			field_ff <= (phase_ff < (period_ff >> 1)); // R19
		end
	end

	// Lines per frame: hsync leading edges between vsync leading edges
	always_ff @(posedge core_clk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			proc_prev_ff <= 1'b0;
			hs_out_ff <= 1'b0;
			line_acc_ff <= '0;
			line_cnt_ff <= '0;
		end
		else
		begin
			proc_prev_ff <= proc_hs;
			hs_out_ff <= proc_hs; // R18
			if (vs_src && !vs_out_ff && (vs_gate || !ctrl_ff[CTRL_VSF_BIT]))
			begin
				line_cnt_ff <= line_acc_ff; // R18
				line_acc_ff <= '0;
			end
			else if (proc_hs && !proc_prev_ff && line_acc_ff != '1)
				line_acc_ff <= line_acc_ff + 1'b1;
		end
	end

	assign hsync_out = hs_out_ff;
	assign vertical_sync_output = vs_out_ff;
	assign field_odd = field_ff;
endmodule : vsp_sync_proc

// ===== shared/vsp_pkg.sv
package vsp_pkg;
	// Register indices; byte address is four times the index
	localparam logic [7:0] IDX_SEP_THRESH = 8'h11;
	localparam logic [7:0] IDX_COAST_CFG = 8'h12;
	localparam logic [7:0] IDX_STATUS = 8'h16;
	localparam logic [7:0] IDX_SLICE_LEVEL = 8'h1d;
	localparam logic [7:0] IDX_HS_WINDOW = 8'h20;
	localparam logic [7:0] IDX_SYNC_CTRL = 8'h21;
	localparam logic [7:0] IDX_LINE_COUNT = 8'h30;
	// Field positions
	localparam int COAST_INT_BIT = 1;
	localparam int COAST_PIN_BIT = 0;
	localparam int COAST_VSRC_BIT = 2;
	localparam int STAT_EXTRA_BIT = 0;
	localparam int STAT_FIELD_BIT = 1;
	localparam int STAT_VS_BIT = 2;
	localparam int STAT_LOCK_BIT = 3;
	localparam int SLICE_LSB = 3;
	localparam int CTRL_REGEN_BIT = 7;
	localparam int CTRL_FILT_BIT = 6;
	localparam int CTRL_VSF_BIT = 5;
	localparam int CTRL_CSRC_BIT = 4;
	// Values after reset
	localparam logic [7:0] RST_SEP_THRESH = 8'h20;
	localparam logic [2:0] RST_COAST_CFG = 3'h0;
	localparam logic [4:0] RST_SLICE_LEVEL = 5'h0f;
	localparam logic [7:0] RST_HS_WINDOW = 8'h0a;
	localparam logic [7:0] RST_SYNC_CTRL = 8'he0;
	// Timing
	localparam int CLK_PERIOD_NS = 10;
	localparam int SEP_UNIT_NS = 200;
	localparam int WIN_UNIT_NS = 25;
	localparam int SEP_TICK_CYC = SEP_UNIT_NS / CLK_PERIOD_NS;
	localparam int WIN_UNIT_CYC = WIN_UNIT_NS / CLK_PERIOD_NS;
	localparam int REGEN_WIDTH_CYC = 32;
	localparam int VS_GUARD_CYC = 16;
	localparam int LOCK_MISS_LIMIT = 8;
	typedef enum logic {VSP_SEEK = 1'b0, VSP_HOLD = 1'b1} vsp_sep_t;
endpackage : vsp_pkg

// ===== tb/vsp_src_model.sv
module vsp_src_model
(
	input wire logic core_clk,
	input wire logic run,
	input wire logic vs_on,
	input wire logic extra,
	output logic hsync_in,
	output logic vsync_in,
	output logic green_sync_input
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt = 0;
	initial
	begin
		hsync_in = 1'b0;
		vsync_in = 1'b0;
	end
	// Lines of 400 cycles, 20-cycle pulse, optional mid-line intruder
	always @(posedge core_clk)
	begin
		cnt <= (run && cnt < 399) ? cnt + 1 : 0;
		hsync_in <= run && (cnt < 20 || extra && cnt >= 200 && cnt < 204);
		vsync_in <= vs_on;
	end
	// Composite: frame pulse merged over the line pulses
	assign green_sync_input = hsync_in | vsync_in;
endmodule : vsp_src_model

// ===== tb/vsp_sync_proc_asserts.sv
module vsp_sync_proc_asserts
(
	input wire logic core_clk,
	input wire logic arst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pslverr,
	input wire logic green_sync_input,
	input wire logic [4:0] slice_level,
	input wire logic sync_on_green,
	input wire logic pll_sync,
	input wire logic pll_coast,
	input wire logic hsync_out,
	input wire logic vertical_sync_output,
	input wire logic field_odd
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!arst_n);
	sequence sog_held;
		$rose(green_sync_input) ##1 green_sync_input[*5];
	endsequence
	sequence err_access;
		psel && penable && !pwrite && pslverr;
	endsequence
	coast_block_a: assert property (pll_coast |-> !pll_sync)
		else $error("pll sync passed during coast");
	slice_reset_a: assert property ($rose(arst_n) |->
		slice_level == 5'h0f)
		else $error("slice level not at reset value");
	sog_follow_a: assert property (sog_held |-> sync_on_green)
		else $error("sync on green missed slicer level");
	vs_apart_a: assert property ($rose(vertical_sync_output) |->
		!$rose(hsync_out))
		else $error("vsync and hsync leading edges together");
	field_hold_a: assert property ($changed(field_odd) |->
		$rose(vertical_sync_output) ||
		$past(vertical_sync_output) && !$past(vertical_sync_output, 2))
		else $error("field flag moved away from vsync edge");
	hs_width_a: assert property ($rose(hsync_out) |-> hsync_out[*8])
		else $error("regenerated hsync too short");
	misalign_err_a: assert property (psel && penable && paddr[1:0] != 2'h0 |-> pslverr)
		else $error("misaligned access accepted");
	err_data_a: assert property (err_access |-> prdata == 32'h0)
		else $error("refused read returned data");
endmodule : vsp_sync_proc_asserts
bind vsp_sync_proc vsp_sync_proc_asserts vsp_sync_proc_asserts_i (
	.core_clk(core_clk), .arst_n(arst_n), .psel(psel), .penable(penable),
	.pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pslverr(pslverr),
	.green_sync_input(green_sync_input), .slice_level(slice_level),
	.sync_on_green(sync_on_green), .pll_sync(pll_sync),
	.pll_coast(pll_coast), .hsync_out(hsync_out),
	.vertical_sync_output(vertical_sync_output), .field_odd(field_odd));

// ===== tb/video_sync_processing_bench.sv
module video_sync_processing_bench import vsp_pkg::*;;
	timeunit 1ns;
	timeprecision 1ns;
	logic core_clk = 1'b0, arst_n = 1'b0, psel = 1'b0, penable = 1'b0;
	logic pwrite = 1'b0, coast_in = 1'b0, run = 1'b0, vs_on = 1'b0;
	logic extra = 1'b0, err, pready, pslverr, hsync_in, vsync_in;
	logic green_sync_input, sync_on_green, pll_sync, pll_coast, field_odd;
	logic hsync_out, vertical_sync_output;
	logic [4:0] slice_level;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, prdata, q;
	logic [7:0] ri [5] = '{IDX_SEP_THRESH, IDX_COAST_CFG, IDX_SLICE_LEVEL,
		IDX_HS_WINDOW, IDX_SYNC_CTRL};
	logic [31:0] rv [5] = '{32'h20, 32'h0, 32'h78, 32'h0a, 32'he0};
	int fails = 0, check_count = 0;
	always #5 core_clk = ~core_clk;
	vsp_sync_proc vsp_sync_proc_i (.core_clk(core_clk), .arst_n(arst_n),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
		.pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.hsync_in(hsync_in), .vsync_in(vsync_in), .coast_in(coast_in),
		.green_sync_input(green_sync_input), .slice_level(slice_level),
		.sync_on_green(sync_on_green), .pll_sync(pll_sync),
		.pll_coast(pll_coast), .hsync_out(hsync_out),
		.vertical_sync_output(vertical_sync_output), .field_odd(field_odd));
	vsp_src_model vsp_src_model_i (.core_clk(core_clk), .run(run),
		.vs_on(vs_on), .extra(extra), .hsync_in(hsync_in),
		.vsync_in(vsync_in), .green_sync_input(green_sync_input));
	task final_report;
		$display("fails %0d checks %0d", fails, check_count);
		if (fails == 0 && check_count > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : final_report
	task chk(input string s, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			fails++;
			$display("CHECK FAILED %s expected %h seen %h", s, e, g);
		end
	endtask : chk
	task cyc(input int k);
		repeat (k) @(posedge core_clk);
	endtask : cyc
	task apb(input logic w, input logic [7:0] i, input logic [1:0] lo,
		input logic [31:0] d);
		int n;
		n = 0;
		@(posedge core_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= {2'h0, i, lo};
		pwdata <= d;
		@(posedge core_clk);
		penable <= 1'b1;
		do @(posedge core_clk); while (pready !== 1'b1 && ++n < 50);
		if (n >= 50)
		begin
			fails++;
			final_report;
		end
		q = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask : apb
	task frame(input logic [2:0] cfg, input logic pin);
		apb(1'b1, IDX_COAST_CFG, 2'h0, {29'h0, cfg});
		vs_on <= 1'b1;
		cyc(30);
		chk("coast early", {31'h0, pin}, {31'h0, pll_coast});
		chk("vs early", 32'h0, {31'h0, vertical_sync_output});
		cyc(170);
		chk("vs on", 32'h1, {31'h0, vertical_sync_output});
		chk("coast on", 32'h1, {31'h0, pll_coast});
		cyc(400);
		vs_on <= 1'b0;
		cyc(20);
		chk("vs lag", 32'h1, {31'h0, vertical_sync_output});
		cyc(230);
		chk("vs off", 32'h0, {31'h0, vertical_sync_output});
	endtask : frame
	initial
	begin
		cyc(2);
		arst_n <= 1'b1;
		for (int k = 0; k < 5; k++)
		begin
			apb(1'b0, ri[k], 2'h0, 32'h0);
			chk("reset value", rv[k], q);
		end
		chk("slice pins", 32'h0f, {27'h0, slice_level});
		apb(1'b1, IDX_SLICE_LEVEL, 2'h0, 32'ha8);
		cyc(1);
		chk("slice write", 32'h15, {27'h0, slice_level});
		apb(1'b0, 8'h13, 2'h0, 32'h0);
		chk("unmapped", 32'h1, {31'h0, err});
		apb(1'b1, IDX_SEP_THRESH, 2'h2, 32'h55);
		chk("misaligned", 32'h1, {31'h0, err});
		apb(1'b0, IDX_SEP_THRESH, 2'h0, 32'h0);
		chk("refused write", 32'h20, q);
		apb(1'b0, IDX_SEP_THRESH, 2'h1, 32'h0);
		chk("misaligned read", 32'h0, q);
		chk("misaligned read err", 32'h1, {31'h0, err});
		apb(1'b1, IDX_SEP_THRESH, 2'h0, 32'h3);
		apb(1'b1, IDX_SYNC_CTRL, 2'h0, 32'he0);
		apb(1'b1, IDX_COAST_CFG, 2'h0, 32'h0);
		coast_in <= 1'b1;
		cyc(5);
		chk("coast pin", 32'h1, {31'h0, pll_coast});
		chk("pll blocked", 32'h0, {31'h0, pll_sync});
		coast_in <= 1'b0;
		run <= 1'b1;
		cyc(12000);
		apb(1'b0, IDX_STATUS, 2'h0, 32'h0);
		chk("status clean", 32'h8, q & 32'hd);
		extra <= 1'b1;
		cyc(800);
		extra <= 1'b0;
		apb(1'b0, IDX_STATUS, 2'h0, 32'h0);
		chk("extra seen", 32'h1, q & 32'h1);
		apb(1'b1, IDX_STATUS, 2'h0, 32'h1);
		apb(1'b0, IDX_STATUS, 2'h0, 32'h0);
		chk("extra cleared", 32'h0, q & 32'h1);
		frame(3'h1, 1'b1);
		frame(3'h2, 1'b0);
		final_report;
	end
endmodule : video_sync_processing_bench
